/* capcc_pkg.sv */
package capcc_pkg;

    // Register address of the shared configuration byte
    localparam logic [7:0] CFG_ADDR      = 8'hdf;
    localparam logic [7:0] CFG_RESET     = 8'h00;

    // Per-module compare byte windows: base plus module index
    localparam logic [7:0] CMP_LOW_BASE  = 8'he0;
    localparam logic [7:0] CMP_HIGH_BASE = 8'he8;
    localparam int         MODULES_MAX   = 8;

    // Field positions of the configuration byte
    localparam int BIT_RELOAD_SEL = 7;
    localparam int BIT_COV_IRQ_EN = 6;
    localparam int BIT_COV_FLAG   = 5;
    localparam int BIT_LEN_HI     = 1;
    localparam int BIT_LEN_LO     = 0;

    // Mask of the bits that hold state; the rest read zero
    localparam logic [7:0] CFG_LIVE_MASK = 8'he3;

    // Cycle length select encodings
    localparam logic [1:0] LEN_8  = 2'h0;
    localparam logic [1:0] LEN_9  = 2'h1;
    localparam logic [1:0] LEN_10 = 2'h2;
    localparam logic [1:0] LEN_11 = 2'h3;

    // Counter bit whose carry ends a cycle, per length
    localparam logic [3:0] TOP_BIT_8  = 4'h7;
    localparam logic [3:0] TOP_BIT_9  = 4'h8;
    localparam logic [3:0] TOP_BIT_10 = 4'h9;
    localparam logic [3:0] TOP_BIT_11 = 4'ha;

    localparam int         BYTE_W     = 8;
    localparam int         COUNT_W    = 16;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

endpackage

/* capcc_pwm_cycle_config.sv */
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module capcc_pwm_cycle_config #(
    parameter int MODULES = 6
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_n,
    // Special function register port
    input  wire logic [7:0]         i_sfr_addr,
    input  wire logic [7:0]         i_sfr_wdata,
    input  wire logic               i_sfr_wr,
    input  wire logic               i_sfr_rd,
    output logic      [7:0]         o_sfr_rdata,
    // Counter array context
    input  wire logic [15:0]        i_main_count,
    input  wire logic [MODULES-1:0] i_pwm_mode,
    input  wire logic [MODULES-1:0] i_wide_pwm_enable,
    // Results
    output logic [MODULES-1:0]      o_pwm_out,
    output logic                    o_cycle_overflow_irq,
    output logic                    o_cycle_overflow_flag,
    output logic [1:0]              o_cycle_length_select
);

    //////////////////////////////////////////////////////////////////////////
    // Configuration state

    logic       reload_bank_select;
    logic       cycle_overflow_irq_enable;
    logic       cycle_overflow_flag;
    logic [1:0] cycle_length_select;
    logic [15:0] count_prev;

    // Per-module storage, addressed by module index
    // At most eight modules: each byte window is eight addresses wide
    logic [7:0] cmp_low    [MODULES];
    logic [7:0] cmp_high   [MODULES];
    logic [7:0] reload_low [MODULES];
    logic [7:0] reload_high[MODULES];

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    wire        cfg_hit = (i_sfr_addr == capcc_pkg::CFG_ADDR);
    wire [7:0]  low_off = i_sfr_addr - capcc_pkg::CMP_LOW_BASE;
    wire [7:0]  high_off = i_sfr_addr - capcc_pkg::CMP_HIGH_BASE;
    wire        low_hit = (low_off < 8'(MODULES));
    wire        high_hit = (high_off < 8'(MODULES));
    wire        cfg_wr = i_sfr_wr && cfg_hit;

    // Module index of the addressed byte; only meaningful with its hit,
    // sized for the largest module count so every window entry is reachable
    localparam int IDX_W = $clog2(capcc_pkg::MODULES_MAX);
    wire [IDX_W-1:0] low_idx  = low_off[IDX_W-1:0];
    wire [IDX_W-1:0] high_idx = high_off[IDX_W-1:0];

    //////////////////////////////////////////////////////////////////////////
    // Cycle length and overflow detection

    wire [3:0] top_bit =
        (cycle_length_select == capcc_pkg::LEN_8)  ? capcc_pkg::TOP_BIT_8  :
        (cycle_length_select == capcc_pkg::LEN_9)  ? capcc_pkg::TOP_BIT_9  :
        (cycle_length_select == capcc_pkg::LEN_10) ? capcc_pkg::TOP_BIT_10 :
                                                     capcc_pkg::TOP_BIT_11;

    // carry out of the top bit seen as its falling edge
    // Limitation: a software load that clears the top bit also counts,
    // traded for not needing the counter's own carry chain here
    wire cycle_overflow = count_prev[top_bit] && !i_main_count[top_bit];

    // Mask of counter bits inside the short cycle
    // Shift kept one bit wider so the 11-bit mask never overflows
    wire [15:0] len_mask = 16'((17'h00002 << top_bit) - 17'h00001);

    //////////////////////////////////////////////////////////////////////////
    // Next configuration values

    // hardware set wins over a software clear in the same cycle
    wire next_flag = cycle_overflow ||
                     (cfg_wr ? i_sfr_wdata[capcc_pkg::BIT_COV_FLAG]
                             : cycle_overflow_flag);
    wire next_irq_en = cfg_wr ? i_sfr_wdata[capcc_pkg::BIT_COV_IRQ_EN]
                              : cycle_overflow_irq_enable;

    // bank select changes only on a configuration write
    wire next_reload_sel = cfg_wr ? i_sfr_wdata[capcc_pkg::BIT_RELOAD_SEL]
                                  : reload_bank_select;

    // length field taken whole from the write data
    wire [1:0] wr_len_field = i_sfr_wdata[capcc_pkg::BIT_LEN_HI:capcc_pkg::BIT_LEN_LO];
    wire [1:0] next_len_sel = cfg_wr ? wr_len_field : cycle_length_select;

    // request from the values flag and enable take at this edge
    wire next_irq = next_flag && next_irq_en;

    // unused bits tie to zero in the readback image
    wire [7:0] cfg_image = {reload_bank_select,
                            cycle_overflow_irq_enable,
                            cycle_overflow_flag,
                            3'h0,
                            cycle_length_select} & capcc_pkg::CFG_LIVE_MASK;

    //////////////////////////////////////////////////////////////////////////
    // Configuration register

    // only live fields are stored; bits four to two have no flops
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            reload_bank_select        <= capcc_pkg::CFG_RESET[capcc_pkg::BIT_RELOAD_SEL];
            cycle_overflow_irq_enable <= capcc_pkg::CFG_RESET[capcc_pkg::BIT_COV_IRQ_EN];
            cycle_overflow_flag       <= capcc_pkg::CFG_RESET[capcc_pkg::BIT_COV_FLAG];
            cycle_length_select       <= capcc_pkg::LEN_8;
        end
        else
        begin
            reload_bank_select        <= next_reload_sel;
            cycle_overflow_irq_enable <= next_irq_en;
            cycle_overflow_flag       <= next_flag;
            cycle_length_select       <= next_len_sel;
        end
    end

    // Previous counter value for edge detection; same clock, no sync
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count_prev <= capcc_pkg::ZERO_WORD;
        else
            count_prev <= i_main_count;
    end

    //////////////////////////////////////////////////////////////////////////
    // Per-module compare and reload banks

    logic [7:0] rd_low_sel [MODULES];
    logic [7:0] rd_high_sel[MODULES];
    logic [MODULES-1:0] next_pwm;

    // Short lengths that use the reload path (9 to 11 bits)
    wire reload_len = (cycle_length_select != capcc_pkg::LEN_8);

    genvar m;
    generate
        for (m = 0; m < MODULES; m++)
        begin : g_mod
            wire wr_low  = i_sfr_wr && low_hit  && (low_off  == 8'(m));
            wire wr_high = i_sfr_wr && high_hit && (high_off == 8'(m));

            // software writes steered to one bank by the select
            // bytes of the other bank are untouched by the write
            wire cmp_wr_low     = wr_low  && !reload_bank_select;
            wire cmp_wr_high    = wr_high && !reload_bank_select;
            wire reload_wr_low  = wr_low  &&  reload_bank_select;
            wire reload_wr_high = wr_high &&  reload_bank_select;

            // shared short-length PWM unless wide enable set
            wire short_pwm = i_pwm_mode[m] && !i_wide_pwm_enable[m];
            // wide modules see the full counter
            wire wide_pwm = i_pwm_mode[m] && i_wide_pwm_enable[m];

            // reload acts only in 9..11-bit PWM at cycle end
            // 8-bit and wide channels never reload; their bytes only store
            wire do_reload = short_pwm && reload_len && cycle_overflow;

            wire [15:0] cmp_word = {cmp_high[m], cmp_low[m]};

            // length mask applied combinationally, no cycle delay
            wire short_out = ((i_main_count & len_mask) < (cmp_word & len_mask));
            wire wide_out = (i_main_count < cmp_word);

            assign next_pwm[m] = wide_pwm ? wide_out :
                                 short_pwm ? short_out : 1'b0;

            assign rd_low_sel[m]  = reload_bank_select ? reload_low[m]  : cmp_low[m];
            assign rd_high_sel[m] = reload_bank_select ? reload_high[m] : cmp_high[m];

            // compare bank; reload copy at the cycle boundary
            always_ff @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    cmp_low[m]  <= capcc_pkg::ZERO_BYTE;
                    cmp_high[m] <= capcc_pkg::ZERO_BYTE;
                end
                else if (do_reload)
                begin
                    // Reload wins: a CPU write lands a cycle too late anyway
                    cmp_low[m]  <= reload_low[m];
                    cmp_high[m] <= reload_high[m];
                end
                else
                begin
                    if (cmp_wr_low)
                        cmp_low[m] <= i_sfr_wdata;
                    if (cmp_wr_high)
                        cmp_high[m] <= i_sfr_wdata;
                end
            end

            // reload bank readable and writable only while the bank select is set
            always_ff @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    reload_low[m]  <= capcc_pkg::ZERO_BYTE;
                    reload_high[m] <= capcc_pkg::ZERO_BYTE;
                end
                else
                begin
                    if (reload_wr_low)
                        reload_low[m] <= i_sfr_wdata;
                    if (reload_wr_high)
                        reload_high[m] <= i_sfr_wdata;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Read path

    // Byte of the addressed module in each window
    wire [7:0] low_rd  = rd_low_sel[low_idx];
    wire [7:0] high_rd = rd_high_sel[high_idx];

    // Unmapped addresses read zero; the hits guard the index range,
    // so an index past the last module is never passed on
    wire [7:0] rd_data =
        cfg_hit  ? cfg_image :
        low_hit  ? low_rd :
        high_hit ? high_rd :
                   capcc_pkg::ZERO_BYTE;

    // Read data holds until the next read strobe
    // A read in a write's cycle returns the value from before the write
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_sfr_rdata <= capcc_pkg::ZERO_BYTE;
        else if (i_sfr_rd)
            o_sfr_rdata <= rd_data;
    end

    //////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // request mirrors flag and enable as they stand after this edge
    // both come from next values, so the request never lags the flag
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cycle_overflow_irq  <= 1'b0;
            o_cycle_overflow_flag <= 1'b0;
        end
        else
        begin
            o_cycle_overflow_irq  <= next_irq;
            o_cycle_overflow_flag <= next_flag;
        end
    end

    // length copy for the counter array, in step with the field
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_cycle_length_select <= capcc_pkg::LEN_8;
        else
            o_cycle_length_select <= next_len_sel;
    end

    // one cycle of latency on every channel, wide or short
    // channels outside PWM mode hold their output low
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_pwm_out <= '0;
        else
            o_pwm_out <= next_pwm;
    end

endmodule // capcc_pwm_cycle_config

/* capcc_pwm_cycle_config_chk.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module capcc_pwm_cycle_config_chk #(
    parameter int MODULES = 6
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic        i_sfr_wr,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic [15:0] i_main_count,
    input wire logic        o_cycle_overflow_irq,
    input wire logic        o_cycle_overflow_flag,
    input wire logic [1:0]  o_cycle_length_select
);
    // Own copy of the last count, so a carry is seen independently
    logic [15:0] prev_count;
    wire  [3:0]  top_bit  = {2'h0, o_cycle_length_select} + 4'h7;
    wire         cnt_fall = prev_count[top_bit] && !i_main_count[top_bit];
    wire         cfg_wr   = i_sfr_wr && (i_sfr_addr == capcc_pkg::CFG_ADDR);
    wire         cfg_rd   = i_sfr_rd && (i_sfr_addr == capcc_pkg::CFG_ADDR);
    wire  [1:0]  wr_len   = i_sfr_wdata[1:0];

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            prev_count <= 16'h0000;
        else
            prev_count <= i_main_count;
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    //////////////////////////////////////////////////////////////////////////
    // Flag and request
    property p_irq; o_cycle_overflow_irq |-> o_cycle_overflow_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_hold; o_cycle_overflow_flag && !cfg_wr |=> o_cycle_overflow_flag; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_swset; cfg_wr && i_sfr_wdata[5] |=> o_cycle_overflow_flag; endproperty
    a_swset: assert property (p_swset) else $error("flag not set");
    property p_ovf; cnt_fall |=> o_cycle_overflow_flag; endproperty
    a_ovf: assert property (p_ovf) else $error("carry missed");
    property p_noovf; !o_cycle_overflow_flag && !cnt_fall && !cfg_wr |=> !o_cycle_overflow_flag;
    endproperty
    a_noovf: assert property (p_noovf) else $error("stray flag");
    // Config byte fields
    property p_len; cfg_wr |=> o_cycle_length_select == $past(wr_len); endproperty
    a_len: assert property (p_len) else $error("length not stored");
    property p_rdlen; cfg_rd |=> o_sfr_rdata[1:0] == $past(o_cycle_length_select); endproperty
    a_rdlen: assert property (p_rdlen) else $error("length read bad");
    property p_rdz; cfg_rd |=> o_sfr_rdata[4:2] == 3'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("dead bits set");

    c_ovf: cover property (cnt_fall ##1 o_cycle_overflow_irq);
    c_rd: cover property (cfg_rd);
    c_clr: cover property ($fell(o_cycle_overflow_flag));
endmodule // capcc_pwm_cycle_config_chk

bind capcc_pwm_cycle_config capcc_pwm_cycle_config_chk #(.MODULES(MODULES)) u_chk (
    .i_core_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata,
    .i_main_count, .o_cycle_overflow_irq, .o_cycle_overflow_flag, .o_cycle_length_select
);

/* capcc_cpu_model.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Register bus master in the CPU's place; one idle cycle between accesses
module capcc_cpu_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_sfr_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    // Idle lines invert so a stale address never looks held
    task automatic idle();
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        idle();
    end
    // flag cleared only by a written zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        d = i_sfr_rdata;
        idle();
    endtask
endmodule // capcc_cpu_model

/* tb_capcc_pwm_cycle_config.sv */
`timescale 1ns/100ps
module tb_capcc_pwm_cycle_config;
    logic        i_core_clk;
    logic        i_rst_n;
    logic [7:0]  addr, wdata, rdata, rdv;
    logic        wr, rd, irq, flag;
    logic [15:0] count;
    logic [5:0]  pwm_mode, wide_en, pwm_out;
    logic [1:0]  len;
    int          fails = 0;
    int          total_checks = 0;

    capcc_pwm_cycle_config #(.MODULES(6)) dut (.i_core_clk, .i_rst_n, .i_sfr_addr(addr),
        .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
        .i_main_count(count), .i_pwm_mode(pwm_mode), .i_wide_pwm_enable(wide_en),
        .o_pwm_out(pwm_out), .o_cycle_overflow_irq(irq), .o_cycle_overflow_flag(flag),
        .o_cycle_length_select(len));
    capcc_cpu_model cpu (.i_core_clk, .i_sfr_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));

    //////////////////////////////////////////////////////////////////////////
    // Shared compare, read and counter helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
        cpu.rd(a, rdv);
        check(rdv, exp);
    endtask
    task automatic count_to(input logic [15:0] v);
        @(posedge i_core_clk);
        #1;
        count = v;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        #20000;
        fails++;
        report_and_stop();
    end

    initial
    begin
        i_rst_n = 1'b0;
        count = 16'h0000;
        pwm_mode = 6'h3f;
        wide_en = 6'h02;
        repeat (12) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        rcheck(capcc_pkg::CFG_ADDR, 8'h00);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'hff);
        rcheck(capcc_pkg::CFG_ADDR, 8'he3);
        check({7'h00, irq}, 8'h01);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h20);
        rcheck(capcc_pkg::CFG_ADDR, 8'h20);
        check({7'h00, irq}, 8'h00);
        $display("test regs done");
        // Carry of the bit below the top must not count
        for (int s = 0; s < 4; s++)
        begin
            cpu.wr(capcc_pkg::CFG_ADDR, 8'h40 | 8'(s));
            count_to(16'((1 << (s + 7)) - 1));
            count_to(16'(1 << (s + 7)));
            count_to(16'(1 << (s + 7)));
            check({7'h00, flag}, 8'h00);
            count_to(16'((1 << (s + 8)) - 1));
            count_to(16'h0000);
            count_to(16'h0000);
            check({7'h00, flag}, 8'h01);
        end
        // Overflow in the same cycle as a clearing write: the set wins
        count_to(16'h07ff);
        fork
            cpu.wr(capcc_pkg::CFG_ADDR, 8'h43);
            count_to(16'h0000);
        join
        check({7'h00, flag}, 8'h01);
        check({7'h00, irq}, 8'h01);
        $display("test lengths done");
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h00);
        cpu.wr(8'he0, 8'h11);
        cpu.wr(8'he1, 8'h22);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h80);
        cpu.wr(8'he0, 8'h33);
        rcheck(8'he0, 8'h33);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h00);
        rcheck(8'he0, 8'h11);
        count_to(16'h00ff);
        count_to(16'h0100);
        rcheck(8'he0, 8'h11);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h01);
        count_to(16'h01ff);
        count_to(16'h0200);
        rcheck(8'he0, 8'h33);
        count_to(16'h0210);
        count_to(16'h0210);
        count_to(16'h0210);
        check({2'h0, pwm_out}, 8'h01);
        cpu.wr(capcc_pkg::CFG_ADDR, 8'h03);
        count_to(16'h0210);
        check({2'h0, pwm_out}, 8'h00);
        $display("test banks done");
        report_and_stop();
    end
endmodule // tb_capcc_pwm_cycle_config
